// ---- inc/sbt_pkg.sv ----
// shared constants and types of the sixteen bit gated timer
package sbt_pkg;

  // register offsets
  localparam logic [8:0] SBT_OFF_CTRL     = 9'h10E;
  localparam logic [8:0] SBT_OFF_CNT_LOW  = 9'h10C;
  localparam logic [8:0] SBT_OFF_CNT_HIGH = 9'h10D;
  localparam logic [8:0] SBT_OFF_FLAG     = 9'h00C;
  localparam logic [8:0] SBT_OFF_IRQ_EN   = 9'h08C;
  localparam logic [8:0] SBT_OFF_IRQ_CTL  = 9'h00B;

  // field positions
  localparam int SBT_BIT_OVF_FLAG = 0;
  localparam int SBT_BIT_OVF_IE   = 0;
  localparam int SBT_BIT_GLB_EN   = 7;
  localparam int SBT_BIT_PER_EN   = 6;

  // reset values and maximum count
  localparam logic [7:0]  SBT_RST_CTRL = 8'h00;
  localparam logic [15:0] SBT_RST_CNT  = 16'h0000;
  localparam logic [15:0] SBT_CNT_MAX  = 16'hFFFF;

  // prescale codes and terminal counts
  localparam logic [1:0] SBT_PS_DIV1 = 2'h0;
  localparam logic [1:0] SBT_PS_DIV2 = 2'h1;
  localparam logic [1:0] SBT_PS_DIV4 = 2'h2;
  localparam logic [1:0] SBT_PS_DIV8 = 2'h3;
  localparam logic [2:0] SBT_PS_LAST1 = 3'h0;
  localparam logic [2:0] SBT_PS_LAST2 = 3'h1;
  localparam logic [2:0] SBT_PS_LAST4 = 3'h3;
  localparam logic [2:0] SBT_PS_LAST8 = 3'h7;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       gate_polarity;
    logic       gate_enable;
    logic [1:0] prescale_select;
    logic       unused3;
    logic       async_select;
    logic       clock_source_select;
    logic       timer_enable;
  } sbt_ctrl_s;

  // register port request
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sbt_req_s;

endpackage

// ---- hw/sbt_prescaler.sv ----
// prescaler dividing a tick stream by 1, 2, 4 or 8
`timescale 1ns/1ps
module sbt_prescaler
  import sbt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // control
  input  wire logic       clr,
  input  wire logic [1:0] sel,
  // tick in, divided tick out
  input  wire logic       tick,
  output wire logic       pulse
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] last;

  // R4 ratio select
  assign last = (sel == SBT_PS_DIV8) ? SBT_PS_LAST8 :
                (sel == SBT_PS_DIV4) ? SBT_PS_LAST4 :
                // R5 low codes
                (sel == SBT_PS_DIV2) ? SBT_PS_LAST2 : SBT_PS_LAST1;

  assign pulse = tick && !clr && (cnt_q >= last);

  // R6 cleared on count write
  assign cnt_d = clr   ? 3'h0 :
                 pulse ? 3'h0 :
                 tick  ? 3'(cnt_q + 3'h1) : cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  presc_clear_a: assert property (clr |=> cnt_q == 3'h0) // R6
    else $error("prescaler not cleared by count write");
  div_eight_a: assert property ((pulse && sel == SBT_PS_DIV8 && !$changed(sel)) // R4
                                |=> !pulse [*7])
    else $error("divide by eight pulsed too early");
  div_two_a: assert property ((pulse && sel == SBT_PS_DIV2 && !$changed(sel)) |=> !pulse) // R5
    else $error("divide by two pulsed on consecutive ticks");

endmodule // sbt_prescaler

// ---- hw/sbt_timer.sv ----
// sixteen bit gated timer with prescaler, external count input and overflow flag
// Function
// R1: internal source counts system clock divided by selected prescale ratio.
// R2: external source counts rising pin edges, synchronised or asynchronous.
// R3: external mode needs a falling edge before first counted rising edge.
// R4: prescale field bits 5:4; code 11 divides by 8, 10 by 4.
// R5: code 01 divides by 2, code 00 by 1, reset setting.
// R6: prescaler hidden from software, cleared by any count byte write.
// R7: async select bit 2 set counts external pin without synchroniser.
// R8: asynchronous mode counts in sleep; overflow raises wake interrupt.
// R9: mode switch may lose or add one count.
// R10: every single count byte read returns a valid value.
// R11: software stops timer before loading a new count.
// R12: gate enable bit 6 lets counting run only while gate active.
// R13: gate polarity bit 7: 1 active high, 0 active low.
// R14: counting past FFFF wraps to zero and sets overflow flag.
// R15: interrupt request needs flag, timer, peripheral and global enables.
// R16: service software clears overflow flag; hardware never clears it.
// R17: software clears count and flag before re-enabling interrupt.
// R18: only asynchronous mode runs in sleep; wake needs enables too.
// R19: processor resumes after wake, vectors if global enable set.
// R20: clock source select 0 is system clock, 1 external pin.
// R21: software writes to either count byte load the counter directly.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sbt_timer
  import sbt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       ext_count_clock_pin,
  input  wire logic       gate_pin,
  // processor state
  input  wire logic       sleep_mode,
  // requests to the processor
  output wire logic       irq_req,
  output wire logic       wake_req
);

  sbt_req_s   req;
  sbt_ctrl_s  ctrl_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        flag_q;
  logic        flag_d;
  logic        ie_q;
  logic        per_en_q;
  logic        glb_en_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        sync1_q;
  logic        sync2_q;
  logic        prev_q;
  logic        en_q;
  logic        armed_q;
  logic        armed_d;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address decode
  wire sel_ctrl = (req.addr == SBT_OFF_CTRL);
  wire sel_low  = (req.addr == SBT_OFF_CNT_LOW);
  wire sel_high = (req.addr == SBT_OFF_CNT_HIGH);
  wire sel_flag = (req.addr == SBT_OFF_FLAG);
  wire sel_ie   = (req.addr == SBT_OFF_IRQ_EN);
  wire sel_ictl = (req.addr == SBT_OFF_IRQ_CTL);

  wire wr_ctrl = req.wr && sel_ctrl;
  wire wr_low  = req.wr && sel_low;
  wire wr_high = req.wr && sel_high;
  wire wr_flag = req.wr && sel_flag;
  wire wr_ie   = req.wr && sel_ie;
  wire wr_ictl = req.wr && sel_ictl;
  wire wr_cnt  = wr_low || wr_high;

  wire ext_src   = ctrl_q.clock_source_select;
  wire async_ext = ext_src && ctrl_q.async_select;

  // R7 raw pin in async mode, two-stage synchroniser otherwise
  wire ext_lvl  = async_ext ? ext_count_clock_pin : sync2_q;
  wire ext_rise = ext_lvl && !prev_q;
  wire ext_fall = !ext_lvl && prev_q;

  // R18 synchronised and internal counting stop in sleep
  wire run_ok  = ctrl_q.timer_enable && (!sleep_mode || async_ext);
  // R12 gate qualifies only when enabled
  // R13 polarity picks active level
  wire gate_ok = !ctrl_q.gate_enable || (gate_pin == ctrl_q.gate_polarity);
  wire cnt_en  = run_ok && gate_ok;

  // R20 source select
  // R2 counted on rising edge
  // R3 edge counted only once armed
  wire src_tick = ext_src ? (ext_rise && armed_q) : 1'b1;

  wire inc;

  // R1 internal path through the prescaler
  sbt_prescaler u_presc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (wr_cnt),
    .sel     (ctrl_q.prescale_select),
    .tick    (cnt_en && src_tick),
    .pulse   (inc)
  );

  // R14 wrap point
  wire ovf = inc && (cnt_q == SBT_CNT_MAX) && !wr_cnt;

  // R21 byte writes load directly and take priority over counting
  // R11 a write racing a count keeps the written byte, losing that count
  assign cnt_d = wr_low  ? {cnt_q[15:8], req.wdata} :
                 wr_high ? {req.wdata, cnt_q[7:0]} :
                 inc     ? 16'(cnt_q + 16'h0001) : cnt_q;

  // R3 disarm on enable rise or count write; falling edge arms
  wire en_rise = ctrl_q.timer_enable && !en_q;
  assign armed_d = (en_rise || wr_cnt) ? 1'b0 :
                   ext_fall            ? 1'b1 : armed_q;

  // R14 overflow sets the flag
  // R16 software clear; a same-cycle overflow wins
  assign flag_d = ovf || (wr_flag ? req.wdata[SBT_BIT_OVF_FLAG] : flag_q);

  // R10 reads sample the single-domain counter, so each byte is whole
  assign rdata_d = !req.rd  ? 8'h00 :
                   sel_ctrl ? ctrl_q :
                   sel_low  ? cnt_q[7:0] :
                   sel_high ? cnt_q[15:8] :
                   sel_flag ? {7'h00, flag_q} :
                   sel_ie   ? {7'h00, ie_q} :
                   sel_ictl ? {glb_en_q, per_en_q, 6'h00} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= sbt_ctrl_s'(SBT_RST_CTRL);
      cnt_q  <= SBT_RST_CNT;
      flag_q <= 1'b0;
      ie_q   <= 1'b0;
      per_en_q <= 1'b0;
      glb_en_q <= 1'b0;
    end else begin
      // bit 3 is unused and stays zero
      if (wr_ctrl) ctrl_q <= sbt_ctrl_s'(req.wdata & 8'hF7);
      if (wr_ie) ie_q <= req.wdata[SBT_BIT_OVF_IE];
      if (wr_ictl) begin
        glb_en_q <= req.wdata[SBT_BIT_GLB_EN];
        per_en_q <= req.wdata[SBT_BIT_PER_EN];
      end
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
    end
  end

  // R9 switching modes changes pin latency by two cycles, so one edge can be lost or doubled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      en_q    <= 1'b0;
      armed_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      sync1_q <= ext_count_clock_pin;
      sync2_q <= sync1_q;
      prev_q  <= ext_lvl;
      en_q    <= ctrl_q.timer_enable;
      armed_q <= armed_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // R15 request needs all three enables
  assign irq_req  = flag_q && ie_q && per_en_q && glb_en_q;
  // R8 overflow in sleep wakes
  // R18 wake needs timer, timer interrupt and peripheral enables
  // R19 global enable only decides vectoring, not wake
  assign wake_req = sleep_mode && flag_q && ie_q && per_en_q && ctrl_q.timer_enable;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ovf_wrap_a: assert property (ovf |=> cnt_q == 16'h0000 && flag_q) // R14
    else $error("overflow did not wrap and flag");
  flag_hold_a: assert property (flag_q && !wr_flag |=> flag_q) // R16
    else $error("overflow flag cleared by hardware");
  irq_gate_a: assert property ($rose(irq_req) |-> $past(ovf || wr_flag || wr_ie || wr_ictl)) // R15
    else $error("interrupt request rose without overflow or enable write");
  div_one_a: assert property ((ctrl_q.timer_enable && !ext_src && !sleep_mode && gate_ok // R1
                               && ctrl_q.prescale_select == SBT_PS_DIV1 && !wr_cnt)
                              |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("internal divide by one missed a count");
  arm_clear_a: assert property (wr_cnt |=> !armed_q) // R3
    else $error("count write did not disarm edge counting");
  unarmed_hold_a: assert property ((ext_src && !armed_q) |-> !inc) // R3
    else $error("count before falling edge");
  gate_block_a: assert property ((ctrl_q.timer_enable && ctrl_q.gate_enable // R12
                                  && gate_pin != ctrl_q.gate_polarity) |-> !inc)
    else $error("counted while gate inactive");
  sleep_stop_a: assert property ((sleep_mode && !async_ext) |-> !inc) // R18
    else $error("synchronous mode counted in sleep");
  byte_read_a: assert property ((req.rd && sel_low) |=> reg_rdata == $past(cnt_q[7:0])) // R10
    else $error("low byte read mismatch");
  byte_write_a: assert property (wr_high |=> cnt_q[15:8] == $past(req.wdata)) // R21
    else $error("high byte write not loaded");
  low_write_a: assert property (wr_low |=> cnt_q[7:0] == $past(req.wdata)) // R21
    else $error("low byte write not loaded");
  flag_clear_a: assert property ((wr_flag && !req.wdata[SBT_BIT_OVF_FLAG] && !ovf) |=> !flag_q) // R16
    else $error("overflow flag not cleared by software");
  arm_enable_a: assert property (en_rise |=> !armed_q) // R3
    else $error("enable did not disarm edge counting");
  arm_fall_a: assert property ((ext_fall && !en_rise && !wr_cnt) |=> armed_q) // R3
    else $error("falling edge did not arm counting");
  sync_path_a: assert property ((ext_src && !ctrl_q.async_select) // R7
                                |-> sync2_q == $past(ext_count_clock_pin, 2))
    else $error("synchronised pin path has wrong latency");
  ext_count_a: assert property ((ext_src && armed_q && ext_rise && cnt_en && !wr_cnt // R2
                                 && ctrl_q.prescale_select == SBT_PS_DIV1)
                                |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("armed rising edge not counted");
  read_idle_a: assert property (!req.rd |=> reg_rdata == 8'h00) // R10
    else $error("read data not zero outside a read");

  ovf_seen_c: cover property (ovf);
  gated_cnt_c: cover property (ctrl_q.gate_enable && inc);
  sleep_cnt_c: cover property (sleep_mode && async_ext && inc);
  wake_c: cover property (wake_req);
  arm_fall_c: cover property (ext_src && ext_fall && !armed_q);

endmodule // sbt_timer

// ---- verification/sbt_pin_model.sv ----
// pin-side partner: external count clock and gate level
`timescale 1ns/1ps
module sbt_pin_model (
  // clock
  input  wire logic sys_clk,
  // pins
  output logic      ext_count_clock_pin,
  output logic      gate_pin
);
  initial begin
    ext_count_clock_pin = 1'b0;
    gate_pin = 1'b0;
  end
  // pulses start high, so the first rise is unarmed
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      ext_count_clock_pin <= 1'b1;
      repeat (w) @(posedge sys_clk);
      ext_count_clock_pin <= 1'b0;
      repeat (w) @(posedge sys_clk);
    end
  endtask
  task automatic set_gate(input logic g);
    gate_pin <= g;
  endtask
endmodule // sbt_pin_model

// ---- verification/tb.sv ----
// self-checking bench for the sixteen bit gated timer
`timescale 1ns/1ps
module tb;
  import sbt_pkg::*;
  logic        sys_clk, rst, reg_wr, reg_rd, sleep_mode, rd_seen;
  logic        ext_count_clock_pin, gate_pin, irq_req, wake_req;
  logic [8:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] exp_q[$];
  logic [15:0] e, ld;
  // ctrl, gate, sleep, count
  logic [23:0] gt[5] = '{24'h410010, 24'hC10000, 24'hC11010, 24'h810010, 24'h010100};
  // ctrl, pulse width, sleep, count
  logic [23:0] et[4] = '{24'h033003, 24'h071003, 24'h033100, 24'h071103};
  int          num_errors = 0;
  int          n_checks = 0;

  sbt_timer dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_count_clock_pin(ext_count_clock_pin), .gate_pin(gate_pin),
    .sleep_mode(sleep_mode), .irq_req(irq_req), .wake_req(wake_req));
  sbt_pin_model pm (.sys_clk(sys_clk), .ext_count_clock_pin(ext_count_clock_pin),
    .gate_pin(gate_pin));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] x);
    n_checks++;
    if (got !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, x);
    end
  endtask
  // w selects wake_req, else irq_req; sampled mid-cycle, then back on the rising edge
  task automatic chk_bit(input bit w, input logic x);
    @(negedge sys_clk);
    chk({7'h00, w ? wake_req : irq_req}, {7'h00, x});
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] m, input logic [7:0] x);
    exp_q.push_back({m, x});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdcnt(input logic [15:0] x);
    rd(SBT_OFF_CNT_LOW, 8'hFF, x[7:0]);
    rd(SBT_OFF_CNT_HIGH, 8'hFF, x[15:8]);
  endtask
  // loads happen only with the timer stopped
  task automatic load(input logic [15:0] v);
    wr(SBT_OFF_CNT_LOW, v[7:0]);
    wr(SBT_OFF_CNT_HIGH, v[15:8]);
  endtask
  // enable stays high for j + 2 counting edges
  task automatic run(input logic [7:0] c, input int j);
    wr(SBT_OFF_CTRL, c);
    repeat (j) @(posedge sys_clk);
    wr(SBT_OFF_CTRL, 8'h00);
  endtask

  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen === 1'b1) begin
      e = exp_q.pop_front();
      chk(reg_rdata & e[15:8], e[7:0]);
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    end_of_test;
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    sleep_mode = 1'b0;
    rd_seen = 1'b0;
    void'($urandom(89));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(SBT_OFF_CTRL, 8'hFF, SBT_RST_CTRL);
    chk_bit(0, 1'b0);
    wr(SBT_OFF_CTRL, 8'hFE);
    rd(SBT_OFF_CTRL, 8'hFF, 8'hF6);
    wr(9'h1FF, 8'h5A);
    rd(9'h1FF, 8'hFF, 8'h00);
    wr(SBT_OFF_CTRL, 8'h00);
    for (int p = 0; p < 4; p++) begin
      ld = 16'($urandom_range(16'hFF00));
      load(ld);
      run({2'h0, p[1:0], 4'h1}, 14);
      rdcnt(ld + (16'h0010 >> p));
    end
    // leave four ticks in the divide-by-8 prescaler, then reload
    run(8'h31, 2);
    load(ld);
    run(8'h31, 10);
    rdcnt(ld + 16'h0001);
    for (int i = 0; i < 5; i++) begin
      pm.set_gate(gt[i][12]);
      sleep_mode <= gt[i][8];
      load(16'h0000);
      run(gt[i][23:16], 14);
      rdcnt({8'h00, gt[i][7:0]});
    end
    for (int i = 0; i < 4; i++) begin
      sleep_mode <= et[i][8];
      load(16'h0000);
      wr(SBT_OFF_CTRL, et[i][23:16]);
      pm.pulses(4, et[i][15:12]);
      wr(SBT_OFF_CTRL, 8'h00);
      rdcnt({8'h00, et[i][7:0]});
    end
    sleep_mode <= 1'b0;
    wr(SBT_OFF_IRQ_EN, 8'h01);
    wr(SBT_OFF_IRQ_CTL, 8'hC0);
    load(16'hFFFE);
    run(8'h01, 2);
    rdcnt(16'h0002);
    rd(SBT_OFF_FLAG, 8'h01, 8'h01);
    chk_bit(0, 1'b1);
    wr(SBT_OFF_IRQ_CTL, 8'h40);
    chk_bit(0, 1'b0);
    chk_bit(1, 1'b0);
    sleep_mode <= 1'b1;
    wr(SBT_OFF_CTRL, 8'h01);
    chk_bit(1, 1'b1);
    wr(SBT_OFF_IRQ_EN, 8'h00);
    chk_bit(1, 1'b0);
    wr(SBT_OFF_CTRL, 8'h00);
    wr(SBT_OFF_IRQ_EN, 8'h01);
    wr(SBT_OFF_IRQ_CTL, 8'hC0);
    chk_bit(0, 1'b1);
    // flag cleared and count loaded with FFFE while still in sleep
    wr(SBT_OFF_FLAG, 8'h00);
    chk_bit(0, 1'b0);
    load(16'hFFFE);
    wr(SBT_OFF_CTRL, 8'h07);
    pm.pulses(3, 1);
    repeat (2) @(posedge sys_clk);
    chk_bit(1, 1'b1);
    wr(SBT_OFF_CTRL, 8'h00);
    sleep_mode <= 1'b0;
    rd(SBT_OFF_FLAG, 8'h01, 8'h01);
    end_of_test;
  end
endmodule // tb
